// file: inc/dmc_map.svh
// Constants for the direct-mapped cache controller
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

// Tag store geometry and address and data widths
`define DMC_LINES      4096
`define DMC_IDX_W      12
`define DMC_TAG_W      24
`define DMC_PA_W       36
`define DMC_VA_W       18
`define DMC_CDU_AW     15
`define DMC_DATA_W     64

// Line transfer and buffer counts
`define DMC_BEAT_LAST  2'h3
`define DMC_FLUSH_CAP  3'h2
`define DMC_FLUSH_LAST 3'h5
`define DMC_WB_SLOTS   2'h2

// Byte lane masks; the data-unit enables are active low
`define DMC_BE_BYTE    8'h01
`define DMC_BE_HALF    8'h03
`define DMC_BE_WORD    8'h0F
`define DMC_BE_ALL     8'hFF
`define DMC_BE_NONE    8'hFF
`define DMC_BE_FILL    8'h00

`endif

// file: inc/dmc_pkg.sv
// Types for the direct-mapped cache controller
package dmc_pkg;

    // Gray coded along idle, lookup, flush, fill, write
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_LOOKUP = 3'h1,
        ST_FLUSH  = 3'h3,
        ST_FILL   = 3'h2,
        ST_WRITE  = 3'h6
    } dmc_state_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2,
        SZ_DBL  = 2'h3
    } dmc_size_t;

endpackage

// file: design/dmc_tag_array.sv
// Tag store with a processor lookup port and a snoop lookup port
`timescale 1ns/1ps
`include "dmc_map.svh"

module dmc_tag_array (
    input  logic                  clk,
    input  logic                  rstn,
    input  logic [`DMC_IDX_W-1:0] rdIndex,
    output logic [`DMC_TAG_W-1:0] rdTag,
    output logic [1:0]            rdValid,
    output logic [1:0]            rdMod,
    input  logic                  wrEn,
    input  logic [`DMC_IDX_W-1:0] wrIndex,
    input  logic [`DMC_TAG_W-1:0] wrTag,
    input  logic [1:0]            wrValid,
    input  logic [1:0]            wrMod,
    input  logic [`DMC_IDX_W-1:0] snpIndex,
    input  logic [`DMC_TAG_W-1:0] snpTag,
    input  logic                  snpSub,
    output logic                  snpHit
);
    logic [`DMC_TAG_W-1:0]      tagMem [0:`DMC_LINES-1];
    logic [`DMC_LINES-1:0][1:0] valid_q;
    logic [`DMC_LINES-1:0][1:0] mod_q;

    // Address part needs no reset: an entry is dead until valid
    always_ff @(posedge clk) begin
        if (wrEn) begin
            tagMem[wrIndex] <= wrTag;
        end
        rdTag <= tagMem[rdIndex];
    end

    // Status bits; snoop has its own read port, so no duplicate tags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            valid_q <= '0;  // [RL23]
            mod_q   <= '0;
            rdValid <= 2'h0;
            rdMod   <= 2'h0;
            snpHit  <= 1'b0;
        end else begin
            if (wrEn) begin
                valid_q[wrIndex] <= wrValid;
                mod_q[wrIndex]   <= wrMod;
            end
            rdValid <= valid_q[rdIndex];
            rdMod   <= mod_q[rdIndex];
            snpHit  <= valid_q[snpIndex][snpSub]
                       && (tagMem[snpIndex] == snpTag);  // [RL11]
        end
    end

    reset_clear_a : assert property (  // [RL23]
        @(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> (valid_q == '0) && !snpHit)
        else $error("tag valid bits not cleared by reset");

endmodule // dmc_tag_array

// file: design/dmc_cache_ctrl.sv
// Direct-mapped cache controller: lookup, fill, flush, write buffer
`timescale 1ns/1ps
`include "dmc_map.svh"

// What this block does
// [RL1] Two policies: write-through or copy-back
// [RL2] Write-through hit updates cache and memory
// [RL3] Write-through miss goes only to memory
// [RL4] Memory writes queue in background write buffer
// [RL5] Read miss forwards word during line fill
// [RL6] Copy-back write sets the modified bit
// [RL7] Copy-back miss on clean line fetches first
// [RL8] Dirty victim buffered while new line fetches
// [RL9] Read miss on dirty line flushes first
// [RL10] Two sizes, virtual index, physical tag
// [RL11] One tag array serves processor and snoop
// [RL12] Small cache: 4096 lines, index bits 16:5
// [RL13] Hit only when physical tags match
// [RL14] Low five bits pick bytes; whole lines
// [RL15] Large cache: index 17:6, bit 5 sub-block
// [RL16] Hold processor until correct data available
// [RL17] Strobe data after fetch, then release hold
// [RL18] Rest of fill runs without holding
// [RL19] Byte enables from address, size, hit
// [RL20] Copy-back miss writes after line replacement
// [RL21] Both dirty sub-blocks flushed as two blocks
// [RL22] Copy-back memory writes use bursts
// [RL23] Reset clears every valid bit
// [RL24] Write-through never sets shared or modified
// [RL25] Policy input sampled per access, high copy-back
module dmc_cache_ctrl (
    input  logic                   clk,
    input  logic                   rstn,
    input  logic                   copyBackMode,
    input  logic                   bigCache,
    input  logic                   procReq,
    input  logic                   procWrite,
    input  logic [`DMC_VA_W-1:0]   intraModuleAddress,
    input  logic [`DMC_TAG_W-1:0]  physTag,
    input  logic [1:0]             accessSize,
    input  logic [`DMC_DATA_W-1:0] procWrData,
    output logic                   processorHold,
    output logic                   processorDataStrobe,
    output logic [`DMC_DATA_W-1:0] procRdData,
    output logic [`DMC_CDU_AW-1:0] cacheDataUnitAddr,
    output logic [7:0]             cacheByteWriteEnableN,
    output logic [`DMC_DATA_W-1:0] cacheDataUnitWrData,
    input  logic [`DMC_DATA_W-1:0] cacheDataUnitRdData,
    output logic                   memReq,
    output logic                   memWrite,
    output logic                   memBurst,
    output logic [`DMC_PA_W-1:0]   memAddr,
    output logic [7:0]             memByteEn,
    output logic [`DMC_DATA_W-1:0] memWrData,
    input  logic                   memAck,
    input  logic [`DMC_DATA_W-1:0] memRdData,
    input  logic [`DMC_IDX_W-1:0]  snoopIndex,
    input  logic [`DMC_TAG_W-1:0]  snoopTag,
    input  logic                   snoopSub,
    output logic                   snoopHit
);
    dmc_pkg::dmc_state_t state_q, state_d;
    logic [`DMC_VA_W-1:0]   reqAddr_q;
    logic [`DMC_TAG_W-1:0]  reqTag_q, oldTag_q;
    logic [`DMC_DATA_W-1:0] reqWrData_q;
    logic [1:0]             reqSize_q;
    logic                   reqWr_q, reqCb_q;
    logic                   flushSub_q, flushMore_q;
    logic [2:0]             flushCnt_q;
    logic                   fillIssued_q;
    // Tag port
    logic [`DMC_IDX_W-1:0]  idxIn, idxReq, rdIndex;
    logic [`DMC_TAG_W-1:0]  rdTag;
    logic [1:0]             rdValid, rdMod, subBit;
    logic [1:0]             tagWrValid, tagWrMod;
    logic                   tagWe, sub, tagHit, hit, othV, othM;
    // Lookup decisions
    logic lkp, wtWrite, victimDirty, otherDirty, needFlush;
    logic wrHitDo, rdHitDo, wtMissDo, doneLkp, missGo, pushSingle;
    logic flushEnd, flushCommit, flushCap;
    logic [7:0] beBase, beMask;
    // Write buffer: two slots of four beats
    logic [`DMC_DATA_W-1:0] wbData_q [0:7];
    logic [`DMC_PA_W-1:0]   wbAddr_q [0:1];
    logic [7:0]             wbMask_q [0:1];
    logic [1:0]             wbSingle_q;
    logic                   wbHead_q, wbTail;
    logic [1:0]             wbCnt_q;
    logic wbRoom, wbEmpty, singlePend, push, pop;
    // Memory engine
    logic [1:0] memBeat_q, memBeatNx;
    logic       memIsFill_q, memLast, fillBeat, fillLast, earlyStrobe;
    logic       fillWant, fillStart, drainStart, strobeD;
    // Next values of the data-unit port
    logic [`DMC_CDU_AW-1:0] cduAddrD;
    logic [7:0]             cbweND;
    logic [`DMC_DATA_W-1:0] cduDataD;

    // Line index per size; bit 5 always picks the status pair
    assign idxIn   = bigCache ? intraModuleAddress[17:6]
                              : intraModuleAddress[16:5];  // [RL12] [RL15]
    assign idxReq  = bigCache ? reqAddr_q[17:6] : reqAddr_q[16:5];
    assign rdIndex = (state_q == dmc_pkg::ST_IDLE) ? idxIn : idxReq;
    assign sub     = reqAddr_q[5];
    assign subBit  = sub ? 2'h2 : 2'h1;

    dmc_tag_array u_tags (
        .clk      (clk),
        .rstn     (rstn),
        .rdIndex  (rdIndex),
        .rdTag    (rdTag),
        .rdValid  (rdValid),
        .rdMod    (rdMod),
        .wrEn     (tagWe),
        .wrIndex  (idxReq),
        .wrTag    (reqTag_q),
        .wrValid  (tagWrValid),
        .wrMod    (tagWrMod),
        .snpIndex (snoopIndex),
        .snpTag   (snoopTag),
        .snpSub   (snoopSub),
        .snpHit   (snoopHit)
    );

    // Hit and victim classification
    assign tagHit      = (rdTag == reqTag_q);
    assign hit         = tagHit && rdValid[sub];  // [RL13] [RL10]
    assign victimDirty = !tagHit && rdValid[sub] && rdMod[sub];
    assign otherDirty  = bigCache && !tagHit
                         && rdValid[~sub] && rdMod[~sub];  // [RL21]
    assign needFlush   = victimDirty || otherDirty;

    // Lookup outcomes
    assign lkp        = (state_q == dmc_pkg::ST_LOOKUP);
    assign wtWrite    = reqWr_q && !reqCb_q;  // [RL1]
    assign wrHitDo    = lkp && reqWr_q && hit && (reqCb_q || wbRoom);
    assign rdHitDo    = lkp && !reqWr_q && hit;
    assign wtMissDo   = lkp && wtWrite && !hit && wbRoom;  // [RL3]
    assign doneLkp    = wrHitDo || rdHitDo || wtMissDo;
    assign pushSingle = lkp && wtWrite && wbRoom;  // [RL2] [RL4]
    // A dirty victim needs an empty buffer, room for two blocks
    assign missGo     = lkp && !hit && !wtWrite
                        && (!needFlush || wbEmpty);  // [RL7]

    // Byte enables from low address bits and size
    assign beBase = (reqSize_q == dmc_pkg::SZ_BYTE) ? `DMC_BE_BYTE :
                    (reqSize_q == dmc_pkg::SZ_HALF) ? `DMC_BE_HALF :
                    (reqSize_q == dmc_pkg::SZ_WORD) ? `DMC_BE_WORD :
                                                      `DMC_BE_ALL;
    assign beMask = beBase << reqAddr_q[2:0];  // [RL19]

    // New tag entry: other sub-block survives only on the same tag
    assign othV       = tagHit && rdValid[~sub];
    assign othM       = tagHit && rdMod[~sub];
    assign tagWe      = (wrHitDo && reqCb_q) || fillLast;
    assign tagWrValid = !fillLast ? rdValid :
                        sub ? {1'b1, othV} : {othV, 1'b1};
    // Modified only set by copy-back writes; shared never stored
    assign tagWrMod   = !fillLast ? (rdMod | subBit) :
                        sub ? {reqWr_q, othM}
                            : {othM, reqWr_q};  // [RL6] [RL24]

    // Flush walk: address beats 0..3, data two cycles later
    assign flushEnd    = (state_q == dmc_pkg::ST_FLUSH)
                         && (flushCnt_q == `DMC_FLUSH_LAST);
    assign flushCap    = (state_q == dmc_pkg::ST_FLUSH)
                         && (flushCnt_q >= `DMC_FLUSH_CAP);
    assign flushCommit = flushEnd;  // [RL8] [RL9]

    // Write buffer bookkeeping
    assign wbTail     = wbHead_q ^ wbCnt_q[0];
    assign wbRoom     = (wbCnt_q != `DMC_WB_SLOTS);
    assign wbEmpty    = (wbCnt_q == 2'h0);
    assign push       = pushSingle || flushCommit;
    assign pop        = memLast && !memIsFill_q;
    // A queued single store may alias the line about to be fetched
    assign singlePend = (!wbEmpty && wbSingle_q[wbHead_q])
                        || (!wbRoom && wbSingle_q[!wbHead_q]);

    // Memory engine: fill has priority unless a single store is queued, drain fills the gaps
    assign fillWant   = (state_q == dmc_pkg::ST_FILL) && !fillIssued_q;
    assign fillStart  = fillWant && !memReq && !singlePend;
    assign drainStart = !memReq && !wbEmpty && !fillStart;  // [RL4]
    assign memLast    = memAck && (!memBurst
                        || (memBeat_q == `DMC_BEAT_LAST));
    assign memBeatNx  = memBeat_q + 2'h1;
    assign fillBeat   = memAck && memIsFill_q;
    assign fillLast   = fillBeat && memLast;
    // Requested word goes out while the rest still streams in
    assign earlyStrobe = fillBeat && !reqWr_q
                         && (memBeat_q == reqAddr_q[4:3]);  // [RL5]
    assign strobeD    = doneLkp || earlyStrobe
                        || (state_q == dmc_pkg::ST_WRITE);  // [RL17]

    // Data-unit port; fill, flush and write never overlap
    assign cduAddrD = fillBeat ? {reqAddr_q[17:5], memBeat_q} :
                      (state_q == dmc_pkg::ST_FLUSH) ?
                      {reqAddr_q[17:6], flushSub_q, flushCnt_q[1:0]} :
                      reqAddr_q[17:3];  // [RL14]
    assign cbweND   = fillBeat ? `DMC_BE_FILL :
                      (wrHitDo || state_q == dmc_pkg::ST_WRITE) ?
                      ~beMask : `DMC_BE_NONE;  // [RL19] [RL20]
    assign cduDataD = fillBeat ? memRdData : reqWrData_q;

    // Controller state
    always_comb begin
        state_d = state_q;
        case (state_q)
            dmc_pkg::ST_IDLE: begin
                if (procReq) state_d = dmc_pkg::ST_LOOKUP;
            end
            dmc_pkg::ST_LOOKUP: begin
                if (doneLkp) state_d = dmc_pkg::ST_IDLE;
                else if (missGo && needFlush) state_d = dmc_pkg::ST_FLUSH;
                else if (missGo) state_d = dmc_pkg::ST_FILL;
            end
            dmc_pkg::ST_FLUSH: begin
                if (flushEnd && !flushMore_q) state_d = dmc_pkg::ST_FILL;
            end
            dmc_pkg::ST_FILL: begin
                if (fillLast && reqWr_q) state_d = dmc_pkg::ST_WRITE;
                else if (fillLast) state_d = dmc_pkg::ST_IDLE;
            end
            default: state_d = dmc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) state_q <= dmc_pkg::ST_IDLE;
        else state_q <= state_d;
    end

    // Request capture; policy sampled for each access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reqAddr_q   <= '0;
            reqTag_q    <= '0;
            reqWrData_q <= '0;
            reqSize_q   <= 2'h0;
            reqWr_q     <= 1'b0;
            reqCb_q     <= 1'b0;
        end else if (state_q == dmc_pkg::ST_IDLE && procReq) begin
            reqAddr_q   <= intraModuleAddress;
            reqTag_q    <= physTag;
            reqWrData_q <= procWrData;
            reqSize_q   <= accessSize;
            reqWr_q     <= procWrite;
            reqCb_q     <= copyBackMode;  // [RL25]
        end
    end

    // Victim capture and flush sequencing; dirty sub first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oldTag_q    <= '0;
            flushSub_q  <= 1'b0;
            flushMore_q <= 1'b0;
            flushCnt_q  <= 3'h0;
        end else begin
            if (missGo) begin
                oldTag_q    <= rdTag;
                flushSub_q  <= victimDirty ? sub : ~sub;
                flushMore_q <= victimDirty && otherDirty;  // [RL21]
            end else if (flushEnd) begin
                flushSub_q  <= ~flushSub_q;
                flushMore_q <= 1'b0;
            end
            if (state_q != dmc_pkg::ST_FLUSH || flushEnd) flushCnt_q <= 3'h0;
            else flushCnt_q <= flushCnt_q + 3'h1;
        end
    end

    // Hold from a lookup that misses or waits for buffer room until the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            processorHold       <= 1'b0;
            processorDataStrobe <= 1'b0;
            procRdData          <= '0;
        end else begin
            processorDataStrobe <= strobeD;
            if (strobeD) processorHold <= 1'b0;  // [RL18]
            else if (lkp) processorHold <= 1'b1;  // [RL16]
            if (earlyStrobe) procRdData <= memRdData;
        end
    end

    // Data-unit port registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cacheDataUnitAddr     <= '0;
            cacheByteWriteEnableN <= `DMC_BE_NONE;
            cacheDataUnitWrData   <= '0;
        end else begin
            cacheDataUnitAddr     <= cduAddrD;
            cacheByteWriteEnableN <= cbweND;
            cacheDataUnitWrData   <= cduDataD;
        end
    end

    // Write buffer storage; flushed beats and single stores
    always_ff @(posedge clk) begin
        if (flushCap) begin
            wbData_q[{wbTail, 2'(flushCnt_q - `DMC_FLUSH_CAP)}]
                <= cacheDataUnitRdData;
        end else if (pushSingle) begin
            wbData_q[{wbTail, 2'h0}] <= reqWrData_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wbAddr_q[0] <= '0;
            wbAddr_q[1] <= '0;
            wbMask_q[0] <= 8'h00;
            wbMask_q[1] <= 8'h00;
            wbSingle_q  <= 2'h0;
            wbHead_q    <= 1'b0;
            wbCnt_q     <= 2'h0;
        end else begin
            if (flushCommit) begin
                wbAddr_q[wbTail]   <= {oldTag_q, reqAddr_q[11:6],
                                       flushSub_q, 5'h00};
                wbMask_q[wbTail]   <= `DMC_BE_ALL;
                wbSingle_q[wbTail] <= 1'b0;  // [RL22]
            end else if (pushSingle) begin
                wbAddr_q[wbTail]   <= {reqTag_q, reqAddr_q[11:3], 3'h0};
                wbMask_q[wbTail]   <= beMask;
                wbSingle_q[wbTail] <= 1'b1;
            end
            if (pop) wbHead_q <= ~wbHead_q;
            wbCnt_q <= wbCnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // System bus side: one transaction at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memReq       <= 1'b0;
            memWrite     <= 1'b0;
            memBurst     <= 1'b0;
            memAddr      <= '0;
            memByteEn    <= 8'h00;
            memWrData    <= '0;
            memBeat_q    <= 2'h0;
            memIsFill_q  <= 1'b0;
            fillIssued_q <= 1'b0;
        end else begin
            if (state_q != dmc_pkg::ST_FILL) fillIssued_q <= 1'b0;
            else if (fillStart) fillIssued_q <= 1'b1;
            if (memReq) begin
                if (memAck) begin
                    memBeat_q <= memBeatNx;
                    memWrData <= wbData_q[{wbHead_q, memBeatNx}];
                    if (memLast) memReq <= 1'b0;
                end
            end else if (fillStart) begin
                memReq      <= 1'b1;
                memWrite    <= 1'b0;
                memBurst    <= 1'b1;
                memAddr     <= {reqTag_q, reqAddr_q[11:5], 5'h00};
                memByteEn   <= `DMC_BE_ALL;
                memBeat_q   <= 2'h0;
                memIsFill_q <= 1'b1;
            end else if (drainStart) begin
                memReq      <= 1'b1;
                memWrite    <= 1'b1;
                memBurst    <= !wbSingle_q[wbHead_q];  // [RL22]
                memAddr     <= wbAddr_q[wbHead_q];
                memByteEn   <= wbMask_q[wbHead_q];
                memWrData   <= wbData_q[{wbHead_q, 2'h0}];
                memBeat_q   <= 2'h0;
                memIsFill_q <= 1'b0;
            end
        end
    end

    hold_release_a : assert property (  // [RL17]
        @(posedge clk) disable iff (!rstn)
        $fell(processorHold) |-> processorDataStrobe)
        else $error("hold dropped without a data strobe");

    tag_mismatch_a : assert property (  // [RL13]
        @(posedge clk) disable iff (!rstn)
        (lkp && !reqWr_q && (rdTag != reqTag_q)) |=> !processorDataStrobe)
        else $error("read answered despite tag mismatch");

    wt_miss_keep_a : assert property (  // [RL3]
        @(posedge clk) disable iff (!rstn)
        (lkp && wtWrite && !hit) |=> cacheByteWriteEnableN == `DMC_BE_NONE)
        else $error("write-through miss wrote the cache");

    wt_hit_both_a : assert property (  // [RL2]
        @(posedge clk) disable iff (!rstn)
        (lkp && wtWrite && hit && wbRoom)
        |=> (cacheByteWriteEnableN != `DMC_BE_NONE) && processorDataStrobe
            && (wbCnt_q != 2'h0))
        else $error("write-through hit missed cache or buffer");

    cb_sets_mod_a : assert property (  // [RL6]
        @(posedge clk) disable iff (!rstn)
        (tagWe && reqCb_q && reqWr_q) |-> (tagWrMod & subBit) != 2'h0)
        else $error("copy-back write left modified bit clear");

    wt_no_mod_a : assert property (  // [RL24]
        @(posedge clk) disable iff (!rstn)
        (tagWe && !reqCb_q) |-> (tagWrMod & subBit) == 2'h0)
        else $error("write-through set a modified bit");

    write_after_fill_a : assert property (  // [RL20]
        @(posedge clk) disable iff (!rstn)
        (state_q == dmc_pkg::ST_WRITE)
        |-> $past(state_q) == dmc_pkg::ST_FILL
            ##1 cacheByteWriteEnableN != `DMC_BE_NONE)
        else $error("copy-back miss write not after fill");

    flush_first_a : assert property (  // [RL9]
        @(posedge clk) disable iff (!rstn)
        (missGo && needFlush) |=> (state_q == dmc_pkg::ST_FLUSH)[*6])
        else $error("dirty victim not flushed before fill");

    early_word_a : assert property (  // [RL18]
        @(posedge clk) disable iff (!rstn)
        earlyStrobe |=> processorDataStrobe && !processorHold
                        && procRdData == $past(memRdData))
        else $error("forwarded word not released to processor");

endmodule // dmc_cache_ctrl

// file: sim/dmc_mem_model.sv
// Main memory and cache data unit model for the cache controller
`timescale 1ns/1ps
module dmc_mem_model (
    input  logic        clk,
    input  logic        memReq,
    input  logic        memWrite,
    input  logic        memBurst,
    input  logic [35:0] memAddr,
    output logic        memAck,
    output logic [63:0] memRdData,
    input  logic [14:0] duAddr,
    input  logic [7:0]  duWeN,
    input  logic [63:0] duWrData,
    output logic [63:0] duRdData,
    output int          singles,
    output int          bursts
);
    logic [63:0] duArr [0:32767];
    logic [1:0]  beat = 2'h0;
    logic [63:0] pat;

    // Data traceable to line address and beat
    assign pat = {28'h0, memAddr[35:5], beat, 3'h0};
    // Between beats the bus shows inverted data, so stale values never match
    assign memRdData = memAck ? pat : ~pat;
    initial begin
        memAck = 1'b0;
        singles = 0;
        bursts = 0;
    end
    // Ack every other cycle: slow but legal memory
    always @(posedge clk) begin
        memAck <= memReq && !memAck;
        if (memAck) begin
            beat <= beat + 2'h1;
            if (memWrite && memBurst) bursts <= bursts + 1;
            if (memWrite && !memBurst) singles <= singles + 1;
        end
        if (!memReq) beat <= 2'h0;
    end
    // Data unit: active low byte writes, read one cycle later
    always @(posedge clk) begin
        duRdData <= duArr[duAddr];
        for (int i = 0; i < 8; i++)
            if (!duWeN[i]) duArr[duAddr][i*8 +: 8] <= duWrData[i*8 +: 8];
    end
endmodule // dmc_mem_model

// file: sim/dmc_cache_ctrl_tb.sv
// Self-checking bench for the cache controller
`timescale 1ns/1ps
module dmc_cache_ctrl_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cb = 1'b0;
    logic        req = 1'b0;
    logic        wr = 1'b0;
    logic        big = 1'b0;
    logic        snS = 1'b0;
    logic        snHit;
    logic        hold, stb, mReq, mWr, mBur, mAck, sawHold;
    logic [1:0]  sz = 2'h0;
    logic [7:0]  weN, gotBe, mBe, lastBe;
    logic [11:0] snIdx = 12'h000;
    logic [14:0] duA;
    logic [17:0] va = 18'h0;
    logic [23:0] tag = 24'h0;
    logic [23:0] snTag = 24'h0;
    logic [35:0] mA;
    logic [63:0] rd, gotRd, duW, duR, mRd, mWd, lastWd;
    int          lat, singles, bursts, testNo;
    int          errTotal = 0;
    int          samplesChecked = 0;

    dmc_cache_ctrl uut (
        .clk(clk), .rstn(rstn), .copyBackMode(cb), .bigCache(big),
        .procReq(req), .procWrite(wr), .intraModuleAddress(va),
        .physTag(tag), .accessSize(sz), .procWrData(64'h0123456789ABCDEF),
        .processorHold(hold), .processorDataStrobe(stb), .procRdData(rd),
        .cacheDataUnitAddr(duA), .cacheByteWriteEnableN(weN),
        .cacheDataUnitWrData(duW), .cacheDataUnitRdData(duR),
        .memReq(mReq), .memWrite(mWr), .memBurst(mBur), .memAddr(mA),
        .memByteEn(mBe), .memWrData(mWd), .memAck(mAck), .memRdData(mRd),
        .snoopIndex(snIdx), .snoopTag(snTag), .snoopSub(snS),
        .snoopHit(snHit)
    );
    dmc_mem_model mem (
        .clk(clk), .memReq(mReq), .memWrite(mWr), .memBurst(mBur),
        .memAddr(mA), .memAck(mAck), .memRdData(mRd), .duAddr(duA),
        .duWeN(weN), .duWrData(duW), .duRdData(duR), .singles(singles),
        .bursts(bursts)
    );

    always #25 clk = ~clk;

    // Keeps the beat acked last, so drained data can be checked later
    always @(posedge clk) begin
        if (mAck && mWr) begin
            lastWd <= mWd;
            lastBe <= mBe;
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One processor access; request dropped inside the strobe cycle
    task automatic access(input logic w, input logic [17:0] a,
                          input logic [23:0] t, input logic [1:0] s);
        @(negedge clk);
        req = 1'b1;
        wr = w;
        va = a;
        tag = t;
        sz = s;
        lat = 0;
        sawHold = 1'b0;
        do begin
            @(negedge clk);
            lat++;
            sawHold |= hold;
        end while (stb !== 1'b1 && lat < 400);
        if (stb !== 1'b1) errTotal++;  // Strobe never came
        gotRd = rd;
        gotBe = weN;
        req = 1'b0;
        // Room for background fill and write drain
        repeat (40) @(negedge clk);
        testNo++;
        $display("test %0d done after %0d cycles", testNo, lat);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        chk(hold, 1'b0);
        chk(weN, 8'hFF);
        access(1'b0, 18'h00028, 24'h000ABC, 2'h3);
        chk(sawHold, 1'b1);
        chk(gotRd, {28'h0, 24'h000ABC, 7'h01, 2'h1, 3'h0});
        snIdx = 12'h001;
        snTag = 24'h000ABC;
        snS = 1'b1;
        @(negedge clk);
        chk(snHit, 1'b1);
        access(1'b0, 18'h00028, 24'h000ABC, 2'h3);
        chk(lat, 2);
        access(1'b0, 18'h00028, 24'h000ABD, 2'h3);
        chk(gotRd, {28'h0, 24'h000ABD, 7'h01, 2'h1, 3'h0});
        chk(snHit, 1'b0);
        access(1'b1, 18'h0002C, 24'h000ABD, 2'h2);
        chk(gotBe, 8'h0F);
        chk(lat, 2);
        chk(singles, 1);
        chk(lastWd, 64'h0123456789ABCDEF);
        chk(lastBe, 8'hF0);
        access(1'b1, 18'h0002C, 24'h000123, 2'h2);
        chk(gotBe, 8'hFF);
        chk(singles, 2);
        access(1'b0, 18'h0002C, 24'h000ABD, 2'h3);
        chk(lat, 2);
        access(1'b0, 18'h0002C, 24'h000ABE, 2'h3);
        chk(bursts, 0);
        cb = 1'b1;
        access(1'b1, 18'h00100, 24'h000777, 2'h0);
        chk(lat > 2, 1'b1);
        chk(gotBe, 8'hFE);
        chk(singles + bursts, 2);
        access(1'b0, 18'h00100, 24'h000778, 2'h3);
        chk(bursts, 4);
        chk(gotRd, {28'h0, 24'h000778, 7'h08, 2'h0, 3'h0});
        chk(lastWd, {28'h0, 24'h000777, 7'h08, 2'h3, 3'h0});
        chk(lastBe, 8'hFF);
        // Second reset, coming back in the large configuration
        rstn = 1'b0;
        big = 1'b1;
        @(negedge clk);
        rstn = 1'b1;
        access(1'b0, 18'h00200, 24'h000778, 2'h3);
        chk(lat > 2, 1'b1);
        access(1'b0, 18'h20028, 24'h000ABC, 2'h3);
        access(1'b0, 18'h00028, 24'h000ABC, 2'h3);
        chk(lat > 2, 1'b1);
        tally_and_finish;
    end

    // Watchdog well past the expected run of some 570 cycles
    initial begin
        #(4000 * 50);
        errTotal++;
        tally_and_finish;
    end
endmodule // dmc_cache_ctrl_tb
